// ==== hdl/ahp_pkg.sv ====
// Purpose: constants and types shared by the high-pass filter and irq routing block
// Assumes: 8-bit register addresses, 16-bit left-justified signed samples
// Notes:   bit positions follow the register layouts of the routing and filter registers
package ahp_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_FILTER_CFG = 8'h21;
    localparam logic [7:0] ADDR_PIN1_ROUTE = 8'h22;
    localparam logic [7:0] ADDR_PIN2_ROUTE = 8'h25;
    localparam logic [7:0] ADDR_REFERENCE  = 8'h26;
    localparam logic [7:0] ADDR_STATUS     = 8'h27;
    localparam logic [7:0] ADDR_OUT_X_LO   = 8'h28;
    localparam logic [7:0] ADDR_OUT_X_HI   = 8'h29;
    localparam logic [7:0] ADDR_OUT_Y_LO   = 8'h2A;
    localparam logic [7:0] ADDR_OUT_Y_HI   = 8'h2B;
    localparam logic [7:0] ADDR_OUT_Z_LO   = 8'h2C;
    localparam logic [7:0] ADDR_OUT_Z_HI   = 8'h2D;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_FILTER_CFG = 8'h00;
    localparam logic [7:0] RST_PIN1_ROUTE = 8'h00;
    localparam logic [7:0] RST_PIN2_ROUTE = 8'h00;
    localparam logic [7:0] RST_REFERENCE  = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FC_MODE_HI     = 7;
    localparam int FC_MODE_LO     = 6;
    localparam int FC_CUT_HI      = 5;
    localparam int FC_CUT_LO      = 4;
    localparam int FC_OSEL        = 3;
    localparam int FC_HP_AG2      = 1;
    localparam int FC_HP_AG1      = 0;
    localparam int P1_CLICK       = 7;
    localparam int P1_AG1         = 6;
    localparam int P1_AG2         = 5;
    localparam int P1_NEWSET      = 4;
    localparam int P1_WTM         = 2;
    localparam int P1_OVR         = 1;
    localparam logic [7:0] P1_WRITABLE = 8'hF6;
    localparam int P2_CLICK       = 7;
    localparam int P2_AG1         = 6;
    localparam int P2_AG2         = 5;
    localparam int P2_BOOT        = 4;
    localparam int P2_ACT         = 3;
    localparam int P2_POL         = 1;
    localparam logic [7:0] P2_WRITABLE = 8'hFA;
    localparam int ST_NEWSET      = 3;

    // ****************************************
    // filter arithmetic
    // ****************************************
    // cutoff/odr ratio maps to a coefficient 2^-shift
    localparam logic [2:0] CUT_SHIFT_0 = 3'h3;
    localparam logic [2:0] CUT_SHIFT_1 = 3'h4;
    localparam logic [2:0] CUT_SHIFT_2 = 3'h5;
    localparam logic [2:0] CUT_SHIFT_3 = 3'h6;
    // one reference lsb is about 2^8 counts at every full scale
    localparam int REF_SHIFT = 8;
    localparam int FRAC_W    = 8;
    localparam int NUM_AXES  = 3;

    typedef enum logic [1:0] {
        AHP_MODE_RESET_ON_READ = 2'b00,
        AHP_MODE_REFERENCE     = 2'b01,
        AHP_MODE_NORMAL        = 2'b10,
        AHP_MODE_AUTORESET     = 2'b11
    } ahp_mode_t;

    typedef struct packed {
        logic signed [15:0] z;
        logic signed [15:0] y;
        logic signed [15:0] x;
    } ahp_axes_t;

    typedef struct packed {
        logic click;
        logic ag1;
        logic ag2;
        logic wtm;
        logic ovr;
        logic boot;
        logic act;
    } ahp_events_t;

endpackage : ahp_pkg

// ==== hdl/ahp_filter_irq.sv ====
// Purpose: acceleration high-pass filter with mode control and two-pin interrupt routing
// Assumes: samples and events come from logic on clk_sys_in; one register access per cycle
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module ahp_filter_irq (
    // clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_in,
    // register access port
    input  wire logic [7:0]           reg_addr_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    input  wire logic [7:0]           reg_wdata_in,
    output logic      [7:0]           reg_rdata_out,
    output logic                      reg_rvalid_out,
    // sample stream
    input  wire ahp_pkg::ahp_axes_t   sample_in,
    input  wire logic                 sample_valid_in,
    input  wire logic [2:0]           axis_enable_in,
    // event sources
    input  wire ahp_pkg::ahp_events_t events_in,
    // filtered data
    output ahp_pkg::ahp_axes_t        data_out,
    output ahp_pkg::ahp_axes_t        activity_one_data_out,
    output ahp_pkg::ahp_axes_t        activity_two_data_out,
    // interrupt pins
    output logic                      first_irq_pin_out,
    output logic                      second_irq_pin_out
);

    // ****************************************
    // register file
    // ****************************************
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    logic [7:0]       cfg_r,  cfg_nxt;
    logic [7:0]       p1_r,   p1_nxt;
    logic [7:0]       p2_r,   p2_nxt;
    logic [7:0]       ref_r,  ref_nxt;
    logic [7:0]       rdata_r, rdata_nxt;
    logic             rvalid_r, rvalid_nxt;
    logic             ref_access;
    ahp_pkg::ahp_mode_t mode;
    logic [2:0]       cut_shift;
    logic             newset_r, newset_nxt;
    logic [2:0]       hi_read_r, hi_read_nxt;
    logic signed [15:0] out_a [ahp_pkg::NUM_AXES];

    assign mode = ahp_pkg::ahp_mode_t'({cfg_r[ahp_pkg::FC_MODE_HI], cfg_r[ahp_pkg::FC_MODE_LO]});
    // a read or a write of the reference register counts as an access
    assign ref_access = (reg_rd_in || reg_wr_in) && addr_is(reg_addr_in, ahp_pkg::ADDR_REFERENCE);

    always_comb begin
        cfg_nxt    = cfg_r;
        p1_nxt     = p1_r;
        p2_nxt     = p2_r;
        ref_nxt    = ref_r;
        rvalid_nxt = reg_rd_in;
        rdata_nxt  = 8'h00;
        if (reg_wr_in) begin
            if (addr_is(reg_addr_in, ahp_pkg::ADDR_FILTER_CFG)) begin
                cfg_nxt = reg_wdata_in;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_PIN1_ROUTE)) begin
                // reserved bits are not stored, so they read zero
                p1_nxt = reg_wdata_in & ahp_pkg::P1_WRITABLE;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_PIN2_ROUTE)) begin
                p2_nxt = reg_wdata_in & ahp_pkg::P2_WRITABLE;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_REFERENCE)) begin
                ref_nxt = reg_wdata_in;
            end
        end
        if (reg_rd_in) begin
            if (addr_is(reg_addr_in, ahp_pkg::ADDR_FILTER_CFG)) begin
                rdata_nxt = cfg_r;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_PIN1_ROUTE)) begin
                rdata_nxt = p1_r;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_PIN2_ROUTE)) begin
                rdata_nxt = p2_r;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_REFERENCE)) begin
                rdata_nxt = ref_r;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_STATUS)) begin
                rdata_nxt = 8'h00;
                rdata_nxt[ahp_pkg::ST_NEWSET] = newset_r;
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_X_LO)) begin
                rdata_nxt = out_a[0][7:0];
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_X_HI)) begin
                rdata_nxt = out_a[0][15:8];
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_Y_LO)) begin
                rdata_nxt = out_a[1][7:0];
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_Y_HI)) begin
                rdata_nxt = out_a[1][15:8];
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_Z_LO)) begin
                rdata_nxt = out_a[2][7:0];
            end else if (addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_Z_HI)) begin
                rdata_nxt = out_a[2][15:8];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_r    <= ahp_pkg::RST_FILTER_CFG;
            p1_r     <= ahp_pkg::RST_PIN1_ROUTE;
            p2_r     <= ahp_pkg::RST_PIN2_ROUTE;
            ref_r    <= ahp_pkg::RST_REFERENCE;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            cfg_r    <= cfg_nxt;
            p1_r     <= p1_nxt;
            p2_r     <= p2_nxt;
            ref_r    <= ref_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata_out  = rdata_r;
    assign reg_rvalid_out = rvalid_r;

    // ****************************************
    // filter control
    // ****************************************
    logic pend_r, pend_nxt;
    logic trig_evt;
    logic reset_now;
    logic reset_on_sample;

    always_comb begin
        case ({cfg_r[ahp_pkg::FC_CUT_HI], cfg_r[ahp_pkg::FC_CUT_LO]})
            2'b00:   cut_shift = ahp_pkg::CUT_SHIFT_0;
            2'b01:   cut_shift = ahp_pkg::CUT_SHIFT_1;
            2'b10:   cut_shift = ahp_pkg::CUT_SHIFT_2;
            default: cut_shift = ahp_pkg::CUT_SHIFT_3;
        endcase
    end

    // autoreset follows whichever activity generator is fed filtered data
    assign trig_evt = (events_in.ag1 && cfg_r[ahp_pkg::FC_HP_AG1])
                   || (events_in.ag2 && cfg_r[ahp_pkg::FC_HP_AG2]);
    assign reset_now = ref_access
                    && ((mode == ahp_pkg::AHP_MODE_RESET_ON_READ && reg_rd_in)
                        || mode == ahp_pkg::AHP_MODE_AUTORESET);
    assign reset_on_sample = pend_r && sample_valid_in;

    always_comb begin
        pend_nxt = pend_r;
        if (reset_on_sample) begin
            pend_nxt = 1'b0;
        end
        // an event in the consuming cycle arms the following set
        if (mode == ahp_pkg::AHP_MODE_AUTORESET && trig_evt) begin
            pend_nxt = 1'b1;
        end
        if (mode != ahp_pkg::AHP_MODE_AUTORESET) begin
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // ****************************************
    // per-axis datapath
    // ****************************************
    logic signed [15:0] smp [ahp_pkg::NUM_AXES];
    logic signed [15:0] ag1_a [ahp_pkg::NUM_AXES];
    logic signed [15:0] ag2_a [ahp_pkg::NUM_AXES];
    logic signed [15:0] ref_scaled;

    assign smp[0] = sample_in.x;
    assign smp[1] = sample_in.y;
    assign smp[2] = sample_in.z;
    assign ref_scaled = {ref_r, 8'h00};

    genvar g;
    generate
        for (g = 0; g < ahp_pkg::NUM_AXES; g++) begin : g_axis
            logic signed [23:0] lp_r, lp_nxt;
            logic signed [15:0] last_r, last_nxt;
            logic signed [15:0] out_r, out_nxt;
            logic signed [15:0] ag1_r, ag1_nxt;
            logic signed [15:0] ag2_r, ag2_nxt;
            logic signed [24:0] diff;
            logic signed [24:0] step;
            logic signed [15:0] filt;

            always_comb begin
                diff = 25'(signed'({smp[g], 8'h00})) - 25'(lp_r);
                step = diff >>> cut_shift;
                // wraps on overflow; inputs are left-justified with headroom
                if (mode == ahp_pkg::AHP_MODE_REFERENCE) begin
                    filt = smp[g] - ref_scaled;
                end else if (reset_on_sample) begin
                    filt = 16'sh0000;
                end else begin
                    filt = smp[g] - lp_r[23:ahp_pkg::FRAC_W];
                end
                lp_nxt   = lp_r;
                last_nxt = last_r;
                out_nxt  = out_r;
                ag1_nxt  = ag1_r;
                ag2_nxt  = ag2_r;
                if (reset_now) begin
                    lp_nxt = {last_r, 8'h00};
                end
                if (sample_valid_in) begin
                    last_nxt = smp[g];
                    if (reset_on_sample || reset_now) begin
                        lp_nxt = {smp[g], 8'h00};
                    end else begin
                        lp_nxt = 24'(25'(lp_r) + step);
                    end
                    out_nxt = cfg_r[ahp_pkg::FC_OSEL]   ? filt : smp[g];
                    ag1_nxt = cfg_r[ahp_pkg::FC_HP_AG1] ? filt : smp[g];
                    ag2_nxt = cfg_r[ahp_pkg::FC_HP_AG2] ? filt : smp[g];
                end
            end

            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    lp_r   <= 24'h000000;
                    last_r <= 16'h0000;
                    out_r  <= 16'h0000;
                    ag1_r  <= 16'h0000;
                    ag2_r  <= 16'h0000;
                end else begin
                    lp_r   <= lp_nxt;
                    last_r <= last_nxt;
                    out_r  <= out_nxt;
                    ag1_r  <= ag1_nxt;
                    ag2_r  <= ag2_nxt;
                end
            end

            assign out_a[g] = out_r;
            assign ag1_a[g] = ag1_r;
            assign ag2_a[g] = ag2_r;
        end
    endgenerate

    assign data_out              = '{z: out_a[2], y: out_a[1], x: out_a[0]};
    assign activity_one_data_out = '{z: ag1_a[2], y: ag1_a[1], x: ag1_a[0]};
    assign activity_two_data_out = '{z: ag2_a[2], y: ag2_a[1], x: ag2_a[0]};

    // ****************************************
    // new-set flag and pins
    // ****************************************
    logic [2:0] hi_hit;
    logic       pin1_r, pin1_nxt;
    logic       pin2_r, pin2_nxt;

    assign hi_hit = {reg_rd_in && addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_Z_HI),
                     reg_rd_in && addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_Y_HI),
                     reg_rd_in && addr_is(reg_addr_in, ahp_pkg::ADDR_OUT_X_HI)};

    always_comb begin
        hi_read_nxt = hi_read_r | hi_hit;
        newset_nxt  = newset_r;
        if ((hi_read_nxt | ~axis_enable_in) == 3'h7) begin
            newset_nxt = 1'b0;
        end
        // a new set wins over a clear in the same cycle
        if (sample_valid_in) begin
            newset_nxt  = 1'b1;
            hi_read_nxt = 3'h0;
        end
        // data-ready bypasses any latching
        pin1_nxt = (p1_r[ahp_pkg::P1_CLICK]  && events_in.click)
                || (p1_r[ahp_pkg::P1_AG1]    && events_in.ag1)
                || (p1_r[ahp_pkg::P1_AG2]    && events_in.ag2)
                || (p1_r[ahp_pkg::P1_NEWSET] && newset_r)
                || (p1_r[ahp_pkg::P1_WTM]    && events_in.wtm)
                || (p1_r[ahp_pkg::P1_OVR]    && events_in.ovr);
        pin2_nxt = (p2_r[ahp_pkg::P2_CLICK]  && events_in.click)
                || (p2_r[ahp_pkg::P2_AG1]    && events_in.ag1)
                || (p2_r[ahp_pkg::P2_AG2]    && events_in.ag2)
                || (p2_r[ahp_pkg::P2_BOOT]   && events_in.boot)
                || (p2_r[ahp_pkg::P2_ACT]    && events_in.act);
        pin1_nxt = pin1_nxt ^ p2_r[ahp_pkg::P2_POL];
        pin2_nxt = pin2_nxt ^ p2_r[ahp_pkg::P2_POL];
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            newset_r  <= 1'b0;
            hi_read_r <= 3'h0;
            pin1_r    <= 1'b0;
            pin2_r    <= 1'b0;
        end else begin
            newset_r  <= newset_nxt;
            hi_read_r <= hi_read_nxt;
            pin1_r    <= pin1_nxt;
            pin2_r    <= pin2_nxt;
        end
    end

    assign first_irq_pin_out  = pin1_r;
    assign second_irq_pin_out = pin2_r;

endmodule : ahp_filter_irq

`default_nettype wire

// ==== bench/ahp_filter_irq_monitor.sv ====
// Purpose: port-level assertions for the filter and irq routing block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   host-written registers are shadowed from the write strobes
`timescale 1ns/1ps
`default_nettype none
module ahp_filter_irq_monitor (
    // clock and reset
    input wire logic                 clk_sys_in,
    input wire logic                 rst_in,
    // register port
    input wire logic [7:0]           reg_addr_in,
    input wire logic                 reg_wr_in,
    input wire logic                 reg_rd_in,
    input wire logic [7:0]           reg_wdata_in,
    input wire logic [7:0]           reg_rdata_out,
    input wire logic                 reg_rvalid_out,
    // samples and events
    input wire ahp_pkg::ahp_axes_t   sample_in,
    input wire logic                 sample_valid_in,
    input wire logic [2:0]           axis_enable_in,
    input wire ahp_pkg::ahp_events_t events_in,
    // block outputs
    input wire ahp_pkg::ahp_axes_t   data_out,
    input wire ahp_pkg::ahp_axes_t   activity_one_data_out,
    input wire ahp_pkg::ahp_axes_t   activity_two_data_out,
    input wire logic                 first_irq_pin_out,
    input wire logic                 second_irq_pin_out
);
    // ********
    // register shadows
    // ********
    logic [7:0] cfg_r, p1_r, p2_r, ref_r;
    logic [7:0] cfg_nxt, p1_nxt, p2_nxt, ref_nxt;
    always_comb begin
        {cfg_nxt, p1_nxt, p2_nxt, ref_nxt} = {cfg_r, p1_r, p2_r, ref_r};
        if (reg_wr_in) begin
            case (reg_addr_in)
                ahp_pkg::ADDR_FILTER_CFG: cfg_nxt = reg_wdata_in;
                ahp_pkg::ADDR_PIN1_ROUTE: p1_nxt = reg_wdata_in & ahp_pkg::P1_WRITABLE;
                ahp_pkg::ADDR_PIN2_ROUTE: p2_nxt = reg_wdata_in & ahp_pkg::P2_WRITABLE;
                ahp_pkg::ADDR_REFERENCE: ref_nxt = reg_wdata_in;
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            {cfg_r, p1_r, p2_r, ref_r} <= 32'h0000_0000;
        end else begin
            {cfg_r, p1_r, p2_r, ref_r} <= {cfg_nxt, p1_nxt, p2_nxt, ref_nxt};
        end
    end
    // pin levels due from events alone; polarity applied last
    wire logic exp1 = ((events_in.click & p1_r[7]) | (events_in.ag1 & p1_r[6])
        | (events_in.ag2 & p1_r[5]) | (events_in.wtm & p1_r[2])
        | (events_in.ovr & p1_r[1])) ^ p2_r[1];
    wire logic exp2 = ((events_in.click & p2_r[7]) | (events_in.ag1 & p2_r[6])
        | (events_in.ag2 & p2_r[5]) | (events_in.boot & p2_r[4])
        | (events_in.act & p2_r[3])) ^ p2_r[1];
    // ********
    // properties
    // ********
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_newset; sample_valid_in && p1_r[4] && !p2_r[1] && !reg_wr_in; endsequence
    sequence s_quiet; !reg_wr_in; endsequence
    property p_rst_quiet;
        $fell(rst_in) |-> !first_irq_pin_out && !second_irq_pin_out && data_out == '0
            && !reg_rvalid_out;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_rvalid; reg_rd_in |-> ##1 reg_rvalid_out; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    property p_p1_back; reg_rd_in && reg_addr_in == 8'h22 |=> reg_rdata_out == $past(p1_r); endproperty
    a_p1_back: assert property (p_p1_back) else $error("pin1 routing readback");
    property p_p2_back; reg_rd_in && reg_addr_in == 8'h25 |=> reg_rdata_out == $past(p2_r); endproperty
    a_p2_back: assert property (p_p2_back) else $error("pin2 routing readback");
    property p_pin1; !$past(p1_r[4]) |-> first_irq_pin_out == $past(exp1); endproperty
    a_pin1: assert property (p_pin1) else $error("first pin level");
    property p_pin2; second_irq_pin_out == $past(exp2); endproperty
    a_pin2: assert property (p_pin2) else $error("second pin level");
    property p_rdy1; s_newset ##1 s_quiet |=> first_irq_pin_out; endproperty
    a_rdy1: assert property (p_rdy1) else $error("data ready not on first pin");
    property p_raw;
        sample_valid_in |=> ($past(cfg_r[3]) || data_out == $past(sample_in))
            && ($past(cfg_r[0]) || activity_one_data_out == $past(sample_in))
            && ($past(cfg_r[1]) || activity_two_data_out == $past(sample_in));
    endproperty
    a_raw: assert property (p_raw) else $error("unfiltered path differs");
    property p_ref;
        sample_valid_in && cfg_r[3] && cfg_r[7:6] == 2'b01
            |=> data_out.x == 16'($past(sample_in.x) - $past({ref_r, 8'h00}));
    endproperty
    a_ref: assert property (p_ref) else $error("reference subtraction");
endmodule : ahp_filter_irq_monitor
`default_nettype wire

// ==== bench/ahp_sensor_model.sv ====
// Purpose: sensor front end handing whole x/y/z sets to the block
// Assumes: one set per fire_in pulse
// Notes:   between sets the bus is not held, it flips every cycle
`timescale 1ns/1ps
`default_nettype none
module ahp_sensor_model (
    input  wire logic               clk_sys_in,
    input  wire logic               fire_in,
    input  wire ahp_pkg::ahp_axes_t value_in,
    output var ahp_pkg::ahp_axes_t  sample_out,
    output var logic                sample_valid_out
);
    initial begin
        sample_out       = '0;
        sample_valid_out = 1'b0;
    end
    always @(posedge clk_sys_in) begin
        sample_valid_out <= fire_in;
        // a stale set must never pass for a fresh one
        sample_out <= fire_in ? value_in : ~sample_out;
    end
endmodule : ahp_sensor_model
`default_nettype wire

// ==== bench/tb_ahp_filter_irq.sv ====
// Purpose: directed bench for the filter and irq routing block
// Assumes: inputs change at rising edges, outputs read 1 ns later
// Notes:   filter checks use reset points and reference subtraction, not the exact decay
`timescale 1ns/1ps
`default_nettype none
module tb_ahp_filter_irq;
    logic                 clk_sys_in = 1'b0;
    logic                 rst_in     = 1'b1;
    logic [7:0]           reg_addr   = 8'h00;
    logic                 reg_wr     = 1'b0;
    logic                 reg_rd     = 1'b0;
    logic [7:0]           reg_wdata  = 8'h00;
    logic [7:0]           reg_rdata;
    logic                 reg_rvalid;
    logic                 fire       = 1'b0;
    ahp_pkg::ahp_axes_t   value      = '0;
    ahp_pkg::ahp_axes_t   sample;
    logic                 sample_valid;
    ahp_pkg::ahp_events_t events     = '0;
    ahp_pkg::ahp_axes_t   data_o, act1_o, act2_o;
    logic                 pin1, pin2;
    int                   bad_count  = 0;
    int                   n_tests    = 0;
    localparam ahp_pkg::ahp_axes_t S_A = 48'h1000_F000_4000;
    localparam ahp_pkg::ahp_axes_t S_B = 48'hC000_2000_A000;
    localparam ahp_pkg::ahp_axes_t S_C = 48'h0800_3000_E000;
    logic [7:0] route1 [3] = '{8'hE6, 8'hE6, 8'h40};
    logic [7:0] route2 [3] = '{8'hF8, 8'hFA, 8'h20};
    logic [6:0] mask1 [3]  = '{7'h7C, 7'h7C, 7'h20};
    logic [6:0] mask2 [3]  = '{7'h73, 7'h73, 7'h10};
    logic [7:0] refs [2]   = '{8'h05, 8'hFB};
    always #2 clk_sys_in = ~clk_sys_in;
    ahp_sensor_model model_u (.clk_sys_in(clk_sys_in), .fire_in(fire), .value_in(value),
        .sample_out(sample), .sample_valid_out(sample_valid));
    ahp_filter_irq dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid), .sample_in(sample),
        .sample_valid_in(sample_valid), .axis_enable_in(3'b101), .events_in(events),
        .data_out(data_o), .activity_one_data_out(act1_o), .activity_two_data_out(act2_o),
        .first_irq_pin_out(pin1), .second_irq_pin_out(pin2));
    // ********
    // access tasks
    // ********
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int k;
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        for (k = 0; k < 4; k++) begin
            #1;
            if (reg_rvalid === 1'b1) break;
            @(posedge clk_sys_in);
        end
        d = reg_rdata;
        // a missing answer ends the run
        if (k == 4) begin
            bad_count++;
            test_done();
        end
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({40'h0, d}, {40'h0, exp});
    endtask : rc
    task automatic smp(input ahp_pkg::ahp_axes_t v);
        @(posedge clk_sys_in);
        fire  <= 1'b1;
        value <= v;
        @(posedge clk_sys_in);
        fire <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask : smp
    // ********
    // main sequence
    // ********
    initial begin
        logic [7:0]  d;
        logic [15:0] rr;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rc(8'h21, 8'h00);
        rc(8'h22, 8'h00);
        rc(8'h25, 8'h00);
        rc(8'h26, 8'h00);
        wr(8'h22, 8'hFF);
        rc(8'h22, 8'hF6);
        wr(8'h25, 8'hFF);
        rc(8'h25, 8'hFA);
        wr(8'h30, 8'hAA);
        rc(8'h30, 8'h00);
        for (int c = 0; c < 3; c++) begin
            wr(ahp_pkg::ADDR_PIN1_ROUTE, route1[c]);
            wr(ahp_pkg::ADDR_PIN2_ROUTE, route2[c]);
            for (int i = 0; i < 7; i++) begin
                @(posedge clk_sys_in);
                events <= ahp_pkg::ahp_events_t'(7'h01 << i);
                repeat (2) @(posedge clk_sys_in);
                #1;
                chk({46'h0, pin1, pin2}, {46'h0, mask1[c][i] ^ route2[c][1],
                    mask2[c][i] ^ route2[c][1]});
            end
        end
        @(posedge clk_sys_in);
        events <= '0;
        wr(ahp_pkg::ADDR_PIN2_ROUTE, 8'h00);
        wr(ahp_pkg::ADDR_PIN1_ROUTE, 8'h10);
        smp(S_A);
        chk({47'h0, pin1}, 48'h1);
        rc(ahp_pkg::ADDR_STATUS, 8'h08);
        rc(ahp_pkg::ADDR_OUT_X_LO, S_A.x[7:0]);
        rc(ahp_pkg::ADDR_OUT_X_HI, S_A.x[15:8]);
        chk({47'h0, pin1}, 48'h1);
        rc(ahp_pkg::ADDR_OUT_Z_HI, S_A.z[15:8]);
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk({47'h0, pin1}, 48'h0);
        wr(ahp_pkg::ADDR_PIN1_ROUTE, 8'h00);
        wr(ahp_pkg::ADDR_FILTER_CFG, 8'h08);
        smp(S_A);
        rd(ahp_pkg::ADDR_REFERENCE, d);
        smp(S_A);
        chk(data_o, 48'h0);
        wr(ahp_pkg::ADDR_FILTER_CFG, 8'h88);
        smp(S_B);
        rd(ahp_pkg::ADDR_REFERENCE, d);
        smp(S_B);
        chk({47'h0, data_o == 48'h0}, 48'h0);
        wr(ahp_pkg::ADDR_FILTER_CFG, 8'h48);
        for (int i = 0; i < 2; i++) begin
            wr(ahp_pkg::ADDR_REFERENCE, refs[i]);
            rr = {refs[i], 8'h00};
            smp(S_A);
            chk(data_o, {S_A.z - rr, S_A.y - rr, S_A.x - rr});
        end
        // autoreset armed by activity generator one, which is also filtered
        wr(ahp_pkg::ADDR_FILTER_CFG, 8'hC9);
        smp(S_A);
        smp(S_B);
        @(posedge clk_sys_in);
        events <= 7'h20;
        @(posedge clk_sys_in);
        events <= '0;
        smp(S_C);
        chk(data_o, 48'h0);
        chk(act1_o, 48'h0);
        chk(act2_o, S_C);
        smp(S_A);
        wr(ahp_pkg::ADDR_REFERENCE, 8'h00);
        smp(S_A);
        chk(data_o, 48'h0);
        for (int c = 0; c < 4; c++) begin
            wr(ahp_pkg::ADDR_FILTER_CFG, {2'b10, 2'(c), 4'h8});
            rc(ahp_pkg::ADDR_FILTER_CFG, {2'b10, 2'(c), 4'h8});
        end
        test_done();
    end
endmodule : tb_ahp_filter_irq
bind ahp_filter_irq ahp_filter_irq_monitor mon_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .sample_in(sample_in), .sample_valid_in(sample_valid_in),
    .axis_enable_in(axis_enable_in), .events_in(events_in), .data_out(data_out),
    .activity_one_data_out(activity_one_data_out),
    .activity_two_data_out(activity_two_data_out),
    .first_irq_pin_out(first_irq_pin_out), .second_irq_pin_out(second_irq_pin_out));
`default_nettype wire
